// [verilog/rbf_span_fill.sv]
// Chosen here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/100ps
`default_nettype none
`include "rbf_map.svh"
module rbf_span_fill
#(
	parameter int FRAC_BITS = 16
)
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	input wire logic i_frag_ready,
	output logic o_frag_valid,
	output logic o_frag_block,
	output logic [15:0] o_frag_x,
	output logic [15:0] o_frag_y,
	output logic [31:0] o_frag_mask,
	output logic [15:0] o_frag_centre_adj,
	output rbf_pkg::rbf_depth_t o_pixel_depth,
	output logic o_busy
);
	import rbf_pkg::*;

	initial
	begin
		if (FRAC_BITS != 16)
		begin
			$error("Rasterizer carries exactly 16 fraction bits");
		end
	end

	rbf_regs_t cur_ff;
	rbf_regs_t nxt_ff;
	logic [31:0] fmt_word;
	logic [31:0] span_mask;
	logic span_last;
	logic [31:0] wr_val;
	logic wr_block;
	logic wr_ok;
	logic sync_on;
	logic can_go;
	logic last_col;
	logic last_row;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	// Byte enables merge a write into the old register contents.
	function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] be);
		logic [31:0] res;
		res = old_v;
		for (int b = 0; b < 4; b++)
		begin
			if (be[b])
			begin
				res[b*8 +: 8] = new_v[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// ------------------------------------------------------------------
	// Submodules
	// ------------------------------------------------------------------
	rbf_mask_fmt u_fmt
	(
		.i_word(wr_val),
		.i_reorder(cur_ff.mode[`RBF_MODE_REORDER]),
		.i_mirror(cur_ff.mode[`RBF_MODE_MIRROR]),
		.i_invert(cur_ff.mode[`RBF_MODE_INVERT]),
		.o_word(fmt_word)
	);

	rbf_span_gen #(.SPAN(32)) u_span
	(
		.i_remain(16'(cur_ff.width - cur_ff.col)),
		.o_mask(span_mask),
		.o_last(span_last)
	);

	// ------------------------------------------------------------------
	// Bus handshake
	// ------------------------------------------------------------------
	// A draw command waits for the engine to go idle so that core writes keep
	// their order; a mask word waits while the previous one is still unused.
	always_comb
	begin
		wr_val = be_merge(32'h0000_0000, i_avs_writedata, i_avs_byteenable);
		wr_block = 1'b0;
		if (i_avs_address == `RBF_REG_DRAW)
		begin
			wr_block = (cur_ff.state != RBF_IDLE);
		end
		if (i_avs_address == `RBF_REG_MASK)
		begin
			wr_block = cur_ff.word_valid;
		end
		o_avs_waitrequest = !i_ce || (i_avs_read && !cur_ff.rd_pend) || (i_avs_write && wr_block);
		wr_ok = i_ce && i_avs_write && !wr_block;
	end

	assign o_avs_readdata = cur_ff.rdata;
	assign o_frag_valid = cur_ff.out_valid;
	assign o_frag_block = cur_ff.out_block;
	assign o_frag_x = cur_ff.out_x;
	assign o_frag_y = cur_ff.out_y;
	assign o_frag_mask = cur_ff.out_mask;
	assign o_frag_centre_adj = cur_ff.out_adj;
	assign o_pixel_depth = cur_ff.depth_act;
	assign o_busy = (cur_ff.state != RBF_IDLE);

	assign sync_on = cur_ff.cmd[`RBF_DRAW_SYNC];
	assign can_go = (!cur_ff.out_valid || i_frag_ready) && (!sync_on || cur_ff.word_valid);
	assign last_col = (cur_ff.col == 16'(cur_ff.width - 16'h0001));
	assign last_row = (cur_ff.row == 16'(cur_ff.height - 16'h0001));

	// ------------------------------------------------------------------
	// Next state: registers, engine and read path
	// ------------------------------------------------------------------
	always_comb
	begin
		nxt_ff = cur_ff;
		// A taken fragment leaves the output unless a new one replaces it.
		if (cur_ff.out_valid && i_frag_ready)
		begin
			nxt_ff.out_valid = 1'b0;
		end
		// Engine.
		unique case (cur_ff.state)
			RBF_IDLE:
			begin
				nxt_ff.state = RBF_IDLE;
			end
			RBF_WAIT:
			begin
				if (cur_ff.word_valid)
				begin
					nxt_ff.state = RBF_EMIT;
				end
			end
			RBF_EMIT:
			begin
				if (sync_on && !cur_ff.word_valid)
				begin
					nxt_ff.state = RBF_WAIT;
				end
				else if (can_go && cur_ff.cmd[`RBF_DRAW_FILL])
				begin
					// One block access per span of up to 32 pixels.
					nxt_ff.out_valid = 1'b1;
					nxt_ff.out_block = 1'b1;
					nxt_ff.out_x = 16'(cur_ff.startx[`RBF_X_INT] + cur_ff.col);
					nxt_ff.out_y = cur_ff.row;
					nxt_ff.out_adj = 16'h0000;
					nxt_ff.out_mask = sync_on ? (span_mask & cur_ff.word) : span_mask;
					nxt_ff.word_valid = 1'b0;
					if (span_last)
					begin
						nxt_ff.col = 16'h0000;
						nxt_ff.row = 16'(cur_ff.row + 16'h0001);
						if (last_row)
						begin
							nxt_ff.state = RBF_IDLE;
						end
					end
					else
					begin
						nxt_ff.col = 16'(cur_ff.col + `RBF_SPAN_PIXELS);
					end
				end
				else if (can_go)
				begin
					// Single fragment; the stored word is already formatted.
					if (!sync_on || cur_ff.word[cur_ff.idx])
					begin
						nxt_ff.out_valid = 1'b1;
						nxt_ff.out_block = 1'b0;
						nxt_ff.out_x = 16'(cur_ff.startx[`RBF_X_INT] + cur_ff.col);
						nxt_ff.out_y = cur_ff.row;
						nxt_ff.out_mask = 32'h0000_0001;
						// Offset from the edge's subpixel start to the pixel centre.
						nxt_ff.out_adj = (cur_ff.cmd[`RBF_DRAW_SUBPIX] && !cur_ff.cmd[`RBF_DRAW_AA])
							? 16'(`RBF_HALF_PIXEL - cur_ff.startx[`RBF_X_FRAC]) : 16'h0000;
					end
					nxt_ff.idx = 5'(cur_ff.idx + 5'h01);
					if (cur_ff.idx == `RBF_LAST_BIT)
					begin
						nxt_ff.word_valid = 1'b0;
					end
					if (last_col)
					begin
						nxt_ff.col = 16'h0000;
						nxt_ff.row = 16'(cur_ff.row + 16'h0001);
						if (last_row)
						begin
							nxt_ff.state = RBF_IDLE;
							nxt_ff.word_valid = 1'b0;
						end
						else if (cur_ff.mode[`RBF_MODE_DISCARD])
						begin
							nxt_ff.word_valid = 1'b0;
							nxt_ff.idx = cur_ff.mode[`RBF_MODE_OFFSET];
						end
					end
					else
					begin
						nxt_ff.col = 16'(cur_ff.col + 16'h0001);
					end
				end
			end
			default:
			begin
				nxt_ff.state = RBF_IDLE;
			end
		endcase
		// Register writes.
		if (wr_ok)
		begin
			unique case (i_avs_address)
				`RBF_REG_MODE:
				begin
					nxt_ff.mode = 10'(be_merge(32'(cur_ff.mode), i_avs_writedata, i_avs_byteenable));
				end
				`RBF_REG_DEPTH:
				begin
					// Takes effect at the next draw, so a running draw is untouched.
					if (wr_val[1:0] != `RBF_DEPTH_RSVD)
					begin
						nxt_ff.depth = rbf_depth_t'(wr_val[1:0]);
					end
				end
				`RBF_REG_FBCFG:
				begin
					// Legacy fill width is kept for readback and drives nothing.
					nxt_ff.fbcfg = be_merge(cur_ff.fbcfg, i_avs_writedata, i_avs_byteenable);
				end
				`RBF_REG_STARTX:
				begin
					nxt_ff.startx = be_merge(cur_ff.startx, i_avs_writedata, i_avs_byteenable);
				end
				`RBF_REG_SIZE:
				begin
					nxt_ff.width = wr_val[`RBF_SIZE_W];
					nxt_ff.height = wr_val[`RBF_SIZE_H];
				end
				`RBF_REG_DRAW:
				begin
					// Only the low flags are kept; the legacy fill step is dropped.
					nxt_ff.cmd = wr_val[3:0];
					nxt_ff.depth_act = cur_ff.depth;
					nxt_ff.col = 16'h0000;
					nxt_ff.row = 16'h0000;
					nxt_ff.word_valid = 1'b0;
					nxt_ff.idx = cur_ff.mode[`RBF_MODE_DISCARD] ? cur_ff.mode[`RBF_MODE_OFFSET] : 5'h00;
					if ((cur_ff.width != 16'h0000) && (cur_ff.height != 16'h0000))
					begin
						nxt_ff.state = wr_val[`RBF_DRAW_SYNC] ? RBF_WAIT : RBF_EMIT;
					end
				end
				`RBF_REG_MASK:
				begin
					// Words arriving with no synced draw running are dropped.
					if ((cur_ff.state != RBF_IDLE) && sync_on)
					begin
						nxt_ff.word = fmt_word;
						nxt_ff.word_valid = 1'b1;
					end
				end
				default:
				begin
					nxt_ff.cmd = cur_ff.cmd;
				end
			endcase
		end
		// Reads take one wait cycle so read data comes from a flip-flop.
		nxt_ff.rd_pend = i_ce && i_avs_read && !cur_ff.rd_pend;
		if (i_avs_read && !cur_ff.rd_pend)
		begin
			unique case (i_avs_address)
				`RBF_REG_MODE: nxt_ff.rdata = 32'(cur_ff.mode);
				`RBF_REG_DEPTH: nxt_ff.rdata = 32'(cur_ff.depth);
				`RBF_REG_LEGACY: nxt_ff.rdata = 32'(cur_ff.depth);
				`RBF_REG_FBCFG: nxt_ff.rdata = cur_ff.fbcfg;
				`RBF_REG_STARTX: nxt_ff.rdata = cur_ff.startx;
				`RBF_REG_SIZE: nxt_ff.rdata = {cur_ff.height, cur_ff.width};
				`RBF_REG_DRAW: nxt_ff.rdata = 32'(cur_ff.cmd);
				`RBF_REG_STATUS: nxt_ff.rdata = {28'h0000000, cur_ff.word_valid,
					cur_ff.state == RBF_WAIT, cur_ff.state != RBF_IDLE, cur_ff.out_valid};
				default: nxt_ff.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// State register
	// ------------------------------------------------------------------
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
		begin
			cur_ff <= '0;
		end
		else if (i_ce)
		begin
			cur_ff <= nxt_ff;
		end
	end
endmodule
`default_nettype wire

// [verilog/rbf_map.svh]
`ifndef RBF_MAP_SVH
`define RBF_MAP_SVH
// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define RBF_REG_MODE 6'h00
`define RBF_REG_DEPTH 6'h04
`define RBF_REG_LEGACY 6'h08
`define RBF_REG_FBCFG 6'h0c
`define RBF_REG_STARTX 6'h10
`define RBF_REG_SIZE 6'h14
`define RBF_REG_DRAW 6'h18
`define RBF_REG_MASK 6'h1c
`define RBF_REG_STATUS 6'h20
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RBF_MODE_REORDER 1:0
`define RBF_MODE_MIRROR 2
`define RBF_MODE_INVERT 3
`define RBF_MODE_DISCARD 4
`define RBF_MODE_OFFSET 9:5
`define RBF_MODE_BITS 9:0
`define RBF_DRAW_SYNC 0
`define RBF_DRAW_FILL 1
`define RBF_DRAW_SUBPIX 2
`define RBF_DRAW_AA 3
`define RBF_SIZE_W 15:0
`define RBF_SIZE_H 31:16
`define RBF_X_INT 31:16
`define RBF_X_FRAC 15:0
// ----------------------------------------------------------------------
// Constants
// ----------------------------------------------------------------------
`define RBF_SPAN_PIXELS 16'h0020
`define RBF_LAST_BIT 5'h1f
`define RBF_HALF_PIXEL 16'h8000
`define RBF_DEPTH_RSVD 2'h3
`endif

// [verilog/rbf_pkg.sv]
package rbf_pkg;
	typedef enum logic [1:0]
	{
		RBF_DEPTH_32 = 2'h0,
		RBF_DEPTH_16 = 2'h1,
		RBF_DEPTH_8 = 2'h2
	} rbf_depth_t;

	// Gray codes along idle, wait, emit.
	typedef enum logic [1:0]
	{
		RBF_IDLE = 2'h0,
		RBF_WAIT = 2'h1,
		RBF_EMIT = 2'h3
	} rbf_state_t;

	typedef struct packed
	{
		logic [9:0] mode;
		rbf_depth_t depth;
		rbf_depth_t depth_act;
		logic [31:0] fbcfg;
		logic [31:0] startx;
		logic [15:0] width;
		logic [15:0] height;
		logic [3:0] cmd;
		rbf_state_t state;
		logic [31:0] word;
		logic word_valid;
		logic [4:0] idx;
		logic [15:0] col;
		logic [15:0] row;
		logic rd_pend;
		logic [31:0] rdata;
		logic out_valid;
		logic out_block;
		logic [15:0] out_x;
		logic [15:0] out_y;
		logic [31:0] out_mask;
		logic [15:0] out_adj;
	} rbf_regs_t;
endpackage

// [verilog/rbf_mask_fmt.sv]
`timescale 1ns/100ps
`default_nettype none
module rbf_mask_fmt
(
	input wire logic [31:0] i_word,
	input wire logic [1:0] i_reorder,
	input wire logic i_mirror,
	input wire logic i_invert,
	output logic [31:0] o_word
);
	import rbf_pkg::*;

	logic [31:0] swapped;
	logic [31:0] mirrored;

	// ------------------------------------------------------------------
	// Byte reorder, mirror and sense inversion of a written mask word
	// ------------------------------------------------------------------
	// Folding the mirror into the stored word lets the engine always walk up.
	always_comb
	begin
		unique case (i_reorder)
			2'h0: swapped = i_word;
			2'h1: swapped = {i_word[23:16], i_word[31:24], i_word[7:0], i_word[15:8]};
			2'h2: swapped = {i_word[15:0], i_word[31:16]};
			2'h3: swapped = {i_word[7:0], i_word[15:8], i_word[23:16], i_word[31:24]};
		endcase
		for (int i = 0; i < 32; i++)
		begin
			mirrored[i] = i_mirror ? swapped[31 - i] : swapped[i];
		end
		o_word = i_invert ? ~mirrored : mirrored;
	end
endmodule
`default_nettype wire

// [verilog/rbf_span_gen.sv]
`timescale 1ns/100ps
`default_nettype none
`include "rbf_map.svh"
module rbf_span_gen
#(
	parameter int SPAN = 32
)
(
	input wire logic [15:0] i_remain,
	output logic [SPAN-1:0] o_mask,
	output logic o_last
)
;
	import rbf_pkg::*;

	initial
	begin
		if (SPAN != 32)
		begin
			$error("Span width must be 32 pixels");
		end
	end

	// ------------------------------------------------------------------
	// Span coverage from pixels left on the scanline
	// ------------------------------------------------------------------
	// Bit 0 is the leftmost pixel; a short tail keeps only its low bits.
	generate
		for (genvar g = 0; g < SPAN; g++)
		begin : g_bit
			assign o_mask[g] = (i_remain > 16'(g));
		end
	endgenerate

	// One span covers the rest of the line when 32 or fewer remain.
	assign o_last = (i_remain <= `RBF_SPAN_PIXELS);
endmodule
`default_nettype wire

// [sim/rbf_checker.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Fragment and bus checker
// ----------------------------------------------------------------------
module rbf_checker
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_ce,
	input wire logic [5:0] i_avs_address,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic o_avs_waitrequest,
	input wire logic i_frag_ready,
	input wire logic o_frag_valid,
	input wire logic o_frag_block,
	input wire logic [15:0] o_frag_x,
	input wire logic [15:0] o_frag_y,
	input wire logic [31:0] o_frag_mask,
	input wire logic [15:0] o_frag_centre_adj,
	input wire rbf_pkg::rbf_depth_t o_pixel_depth
);
	import rbf_pkg::*;
	logic [31:0] sx_ff, sz_ff;
	logic [3:0] drw_ff;
	logic wait_ff, wr_ok;
	logic [15:0] dx;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_reset_n);

	// Shadow the setup taken over the bus, so every fragment can be tied to its cause.
	assign wr_ok = i_ce && i_avs_write && !o_avs_waitrequest;
	assign dx = o_frag_x - sx_ff[31:16];
	always_ff @(posedge i_clk)
	begin
		if (!i_reset_n)
			wait_ff <= 1'b0;
		else if (wr_ok)
		begin
			if (i_avs_address == 6'h10)
				sx_ff <= i_avs_writedata;
			if (i_avs_address == 6'h14)
				sz_ff <= i_avs_writedata;
			if (i_avs_address == 6'h18)
				drw_ff <= i_avs_writedata[3:0];
			if (i_avs_address == 6'h18)
				wait_ff <= i_avs_writedata[0];
			if (i_avs_address == 6'h1c)
				wait_ff <= 1'b0;
		end
	end

	hold_until_taken_a: assert property (o_frag_valid && !i_frag_ready |=> o_frag_valid
		&& $stable({o_frag_x, o_frag_y, o_frag_mask, o_frag_block})) else $error("fragment dropped");
	pixel_single_a: assert property (o_frag_valid && !o_frag_block |-> o_frag_mask == 32'h1)
		else $error("pixel mask not single");
	span_aligned_a: assert property (o_frag_valid && o_frag_block |-> dx[4:0] == 5'h0)
		else $error("span step not 32");
	tail_clear_a: assert property (o_frag_valid && o_frag_block && dx + 16'h20 > sz_ff[15:0]
		|-> (o_frag_mask >> (sz_ff[15:0] - dx)) == 32'h0) else $error("span tail not cleared");
	inside_rect_a: assert property (o_frag_valid |-> o_frag_y < sz_ff[31:16] && dx < sz_ff[15:0])
		else $error("fragment outside rectangle");
	centre_adj_a: assert property (o_frag_valid |-> o_frag_centre_adj ==
		((drw_ff[2] && !drw_ff[3]) ? 16'h8000 - sx_ff[15:0] : 16'h0)) else $error("bad centre adjust");
	no_early_frag_a: assert property (wait_ff |-> !o_frag_valid)
		else $error("fragment before first mask word");
	depth_steady_a: assert property (o_frag_valid && $past(o_frag_valid) |-> $stable(o_pixel_depth))
		else $error("depth changed mid draw");
	depth_write_free_a: assert property (i_ce && i_avs_write && i_avs_address == 6'h04
		|-> !o_avs_waitrequest)
		else $error("depth write stalled");
	depth_legal_a: assert property (o_pixel_depth != 2'h3)
		else $error("reserved depth latched");
endmodule
bind rbf_span_fill rbf_checker i_rbf_checker (.i_clk, .i_reset_n, .i_ce, .i_avs_address,
	.i_avs_write, .i_avs_writedata, .o_avs_waitrequest, .i_frag_ready, .o_frag_valid,
	.o_frag_block, .o_frag_x, .o_frag_y, .o_frag_mask, .o_frag_centre_adj, .o_pixel_depth);
`default_nettype wire

// [sim/rbf_sink.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Downstream fragment consumer
// ----------------------------------------------------------------------
module rbf_sink
(
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_stall,
	output logic o_frag_ready
);
	logic [1:0] cnt_ff;
	// With i_stall set, a rolling pattern refuses one cycle in four, so held fragments are exercised.
	always_ff @(posedge i_clk)
		cnt_ff <= !i_reset_n ? 2'h0 : cnt_ff + 2'h1;
	assign o_frag_ready = !i_stall || cnt_ff != 2'h0;
endmodule
`default_nettype wire

// [sim/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------------
module testbench;
	import rbf_pkg::*;
	typedef struct {logic [15:0] x; logic [15:0] y; logic [31:0] m; logic b; logic [15:0] a;
		rbf_depth_t d;} rbf_note_t;
	logic i_clk, i_reset_n, rd, wr, rdy, stall, wreq, valid, blk, busy, ce;
	logic [5:0] addr;
	logic [31:0] wd, rdata, fmask, got;
	logic [15:0] fx, fy, fadj;
	rbf_depth_t depth, dep;
	rbf_note_t q[$];
	rbf_note_t e;
	int failures, samples_checked, t;

	rbf_span_fill i_rbf_span_fill (.i_clk, .i_reset_n, .i_ce(ce), .i_avs_address(addr),
		.i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'hf),
		.o_avs_readdata(rdata), .o_avs_waitrequest(wreq), .i_frag_ready(rdy), .o_frag_valid(valid),
		.o_frag_block(blk), .o_frag_x(fx), .o_frag_y(fy), .o_frag_mask(fmask),
		.o_frag_centre_adj(fadj), .o_pixel_depth(depth), .o_busy(busy));
	rbf_sink i_rbf_sink (.i_clk, .i_reset_n, .i_stall(stall), .o_frag_ready(rdy));

	// Clock enable drops about one cycle in eight, so frozen bus and fragment cycles are covered.
	always @(posedge i_clk)
		ce <= !i_reset_n || (3'($urandom) != 3'h0);

	initial
	begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end

	task automatic print_verdict();
		if (failures == 0 && samples_checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic miss(input string s);
		failures++;
		$display("wrong value at %0t: %s", $time, s);
	endtask

	// One bus cycle; the request stands until the edge that sees waitrequest low.
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		int n;
		addr <= a;
		wr <= w;
		rd <= !w;
		wd <= d;
		n = 0;
		do
		begin
			@(posedge i_clk);
			n++;
		end
		while (wreq !== 1'b0 && n < 500);
		if (n >= 500)
		begin
			miss("bus hang");
			print_verdict();
		end
		got = rdata;
		wr <= 1'b0;
		rd <= 1'b0;
		@(posedge i_clk);
	endtask

	// Whether bit k of a mask word lets its fragment through, after reorder, mirror and invert.
	function automatic logic acc(input logic [31:0] v, input logic [9:0] m, input int k);
		logic [31:0] f;
		case (m[1:0])
			2'h1: f = {v[23:16], v[31:24], v[7:0], v[15:8]};
			2'h2: f = {v[15:0], v[31:16]};
			2'h3: f = {v[7:0], v[15:8], v[23:16], v[31:24]};
			default: f = v;
		endcase
		return m[3] ^ (m[2] ? f[31 - k] : f[k]);
	endfunction

	// Note every expected fragment, then set up, draw, and feed the mask words.
	task automatic run(input logic [9:0] m, input logic [3:0] dr, input int w, input int h);
		logic [31:0] v[$];
		logic [31:0] sx, msk;
		logic [15:0] adj;
		logic [1:0] d;
		int n, i, k, r, c;
		sx = $urandom;
		d = 2'($urandom);
		stall <= 1'($urandom);
		adj = (dr[2] && !dr[3]) ? 16'h8000 - sx[15:0] : 16'h0;
		n = dr[1] ? h * ((w + 31) / 32) : (m[4] ? h : (w * h + 31) / 32);
		for (i = 0; i < n; i++)
			v.push_back($urandom);
		i = 0;
		for (r = 0; r < h; r++)
			for (c = 0; c < w; c += dr[1] ? 32 : 1)
			begin
				msk = 32'h1;
				if (dr[1])
				begin
					msk = 32'h0;
					for (k = 0; k < 32 && c + k < w; k++)
						msk[k] = !dr[0] || acc(v[i], m, k);
				end
				else
					msk[0] = !dr[0] || acc(v[m[4] ? r : i / 32], m, m[4] ? m[9:5] + c : i % 32);
				// A block fill issues one access per span even when no bit survives.
				if (msk != 32'h0 || dr[1])
					q.push_back('{16'(sx[31:16] + c), 16'(r), msk, dr[1], adj, dep});
				i++;
			end
		bus(1'b1, 6'h0c, $urandom);
		bus(1'b1, 6'h08, $urandom);
		bus(1'b0, 6'h08, 32'h0);
		samples_checked++;
		if (got !== {30'h0, dep})
			miss("legacy depth not read-only");
		bus(1'b1, 6'h14, {16'(h), 16'(w)});
		bus(1'b1, 6'h10, sx);
		bus(1'b1, 6'h00, {22'h0, m});
		bus(1'b1, 6'h18, {28'h0, dr});
		bus(1'b1, 6'h04, {30'h0, d});
		if (d != 2'h3)
			dep = rbf_depth_t'(d);
		bus(1'b0, 6'h04, 32'h0);
		samples_checked++;
		if (got !== {30'h0, dep})
			miss("depth register");
		foreach (v[j])
			bus(1'b1, 6'h1c, v[j]);
		n = 0;
		while ((q.size() != 0 || busy !== 1'b0) && n < 4000)
		begin
			@(posedge i_clk);
			n++;
		end
		if (n >= 4000)
		begin
			miss("drain hang");
			print_verdict();
		end
	endtask

	// Each accepted fragment takes the oldest note and must match it exactly.
	always @(posedge i_clk)
		if (valid === 1'b1 && rdy === 1'b1 && ce === 1'b1)
		begin
			samples_checked++;
			e = q.pop_front();
			if ({fx, fy, fmask, blk, fadj, depth} !== {e.x, e.y, e.m, e.b, e.a, e.d})
				miss("fragment");
		end

	initial
	begin
		#400000;
		miss("timeout");
		print_verdict();
	end

	initial
	begin
		failures = 0;
		samples_checked = 0;
		i_reset_n = 1'b0;
		{rd, wr, stall} = 3'h0;
		addr = 6'h0;
		wd = 32'h0;
		dep = RBF_DEPTH_32;
		void'($urandom(682));
		repeat (3) @(posedge i_clk);
		i_reset_n <= 1'b1;
		@(posedge i_clk);
		for (t = 0; t < 2; t++)
		begin
			bus(1'b0, t[0] ? 6'h3c : 6'h1c, 32'h0);
			samples_checked++;
			if (got !== 32'h0)
				miss("write-only or unmapped read");
		end
		for (t = 0; t < 8; t++)
			run({6'h0, t[0] ^ t[1], t[2], t[1:0]}, {t[2], t[1], 2'h1}, 5, 8);
		run({5'd27, 1'b1, 4'h0}, 4'h1, 5, 3);
		run(10'h0, 4'h1, 7, 9);
		run(10'h0, 4'h4, 6, 3);
		run(10'h0, 4'h2, 40, 2);
		for (t = 0; t < 2; t++)
			run({6'h0, t[0], 3'h0}, 4'h3, 48, 2);
		print_verdict();
	end
endmodule
`default_nettype wire
